//--- tb/iop_pin_model.sv
`default_nettype none

module iop_pin_model (
  input  wire logic [18:0] out_i,
  input  wire logic [18:0] oe_i,
  input  wire logic [18:0] ext_i,
  output logic      [18:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // outside holds levels
  // wire level: driven bits from the port, released bits from outside
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : iop_pin_model

`default_nettype wire

//--- tb/iop_ports_sva.sv
`default_nettype none

module iop_ports_sva (
  input wire logic               CLOCK_I,
  input wire logic               RST_I,
  input wire iop_pkg::iop_addr_t ADDR_I,
  input wire iop_pkg::iop_byte_t WDATA_I,
  input wire logic               WR_I,
  input wire logic               RD_I,
  input wire logic               PHASE_S1_I,
  input wire logic               PHASE_S2_I,
  input wire logic               HIT_O,
  input wire iop_pkg::iop_byte_t RDATA_O,
  input wire logic               RVALID_O,
  input wire logic [3:0]         P6_PIN_I,
  input wire logic [7:0]         P3_OUT_O,
  input wire logic [7:0]         P3_OE_O,
  input wire logic [5:0]         P4_OE_O
);
  import iop_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // taken strobes
  wire logic rd = RD_I && PHASE_S1_I;
  wire logic wr = WR_I && PHASE_S2_I;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  property p_rst;
    $fell(RST_I) |-> ({P3_OUT_O, P3_OE_O, P4_OE_O, RDATA_O, RVALID_O} == 0);
  endproperty
  property p_rv;
    rd |=> RVALID_O;
  endproperty
  property p_norv;
    !rd |=> !RVALID_O && $stable(RDATA_O);
  endproperty
  property p_wr;
    wr && ADDR_I == 16'h0003 |=> P3_OUT_O == $past(WDATA_I);
  endproperty
  property p_hold;
    !(wr && ADDR_I == 16'h0003) |=> $stable(P3_OUT_O);
  endproperty
  property p_oe4;
    !(wr && ADDR_I inside {16'h0004, 16'h1F8A, 16'h1F84}) |=> $stable(P4_OE_O);
  endproperty
  property p_hit;
    ADDR_I inside {[16'h1FCC:16'h1FFF]} |-> !HIT_O;
  endproperty
  property p_rsv;
    rd && ADDR_I >= 16'h1FCC |=> RDATA_O == 8'h00;
  endproperty
  property p_p6;
    rd && ADDR_I == 16'h0006 && $stable(P6_PIN_I) && $past($stable(P6_PIN_I))
      |=> RDATA_O == {4'h0, $past(P6_PIN_I)};
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  a_rv: assert property (p_rv) else $error("read not answered");
  a_norv: assert property (p_norv) else $error("read data moved without read");
  a_wr: assert property (p_wr) else $error("latch write lost");
  a_hold: assert property (p_hold) else $error("latch changed unwritten");
  a_oe4: assert property (p_oe4) else $error("enable changed unwritten");
  a_hit: assert property (p_hit) else $error("reserved address hit");
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  a_p6: assert property (p_p6) else $error("sixth port not read from pins");
  c_rd6: cover property (rd && ADDR_I == 16'h0006);
  c_od: cover property (wr && ADDR_I == 16'h1F83);
  c_rsv: cover property (wr && ADDR_I == 16'h1FCC);
endmodule : iop_ports_sva

bind iop_ports iop_ports_sva chk (.CLOCK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .PHASE_S1_I, .PHASE_S2_I, .HIT_O, .RDATA_O, .RVALID_O, .P6_PIN_I, .P3_OUT_O,
  .P3_OE_O, .P4_OE_O);

`default_nettype wire

//--- tb/iop_ports_tb_top.sv
`default_nettype none

module iop_ports_tb_top;
  import iop_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK_I, RST_I, WR_I, RD_I, PHASE_S1_I, PHASE_S2_I, IND_SIDE_I, HIT_O, RVALID_O;
  iop_addr_t  ADDR_I;
  iop_byte_t  WDATA_I, RDATA_O;
  iop_instr_t INSTR_I;
  logic [0:0] P1_PIN_I, P1_OUT_O, P1_OE_O;
  logic [7:0] P3_PIN_I, P3_OUT_O, P3_OE_O;
  logic [5:0] P4_PIN_I, P4_OUT_O, P4_OE_O;
  logic [3:0] P6_PIN_I, P6_OUT_O, P6_OE_O;
  logic [18:0] ext_v, pins;
  int bad_count, check_count, cyc;
  iop_addr_t ra[9] = '{16'h0001, 16'h0003, 16'h0004, 16'h000B, 16'h1F89,
                       16'h1F8A, 16'h1F8C, 16'h1F83, 16'h1F84};
  iop_byte_t rw[9] = '{8'h01, 8'hFF, 8'h3F, 8'h01, 8'hFF, 8'h3F, 8'h0F, 8'hFF, 8'h3F};

  iop_ports uut (.CLOCK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .PHASE_S1_I,
    .PHASE_S2_I, .INSTR_I, .IND_SIDE_I, .HIT_O, .RDATA_O, .RVALID_O, .P1_PIN_I,
    .P1_OUT_O, .P1_OE_O, .P3_PIN_I, .P3_OUT_O, .P3_OE_O, .P4_PIN_I, .P4_OUT_O,
    .P4_OE_O, .P6_PIN_I, .P6_OUT_O, .P6_OE_O);
  iop_pin_model pm (.out_i({P1_OUT_O, P3_OUT_O, P4_OUT_O, P6_OUT_O}),
    .oe_i({P1_OE_O, P3_OE_O, P4_OE_O, P6_OE_O}), .ext_i(ext_v), .pin_o(pins));
  assign {P1_PIN_I, P3_PIN_I, P4_PIN_I, P6_PIN_I} = pins;

  always #50 CLOCK_I = ~CLOCK_I;

  // hang guard
  always @(posedge CLOCK_I) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input iop_addr_t a, input iop_byte_t d);
    @(negedge CLOCK_I);
    ADDR_I = a;
    WDATA_I = d;
    WR_I = 1'b1;
    PHASE_S2_I = 1'b1;
    @(negedge CLOCK_I);
    WR_I = 1'b0;
    PHASE_S2_I = 1'b0;
  endtask : wr

  // read cycle, answer checked one cycle later
  task automatic rd(input iop_addr_t a, input iop_instr_t k, input logic s, input iop_byte_t e);
    @(negedge CLOCK_I);
    ADDR_I = a;
    INSTR_I = k;
    IND_SIDE_I = s;
    RD_I = 1'b1;
    PHASE_S1_I = 1'b1;
    @(negedge CLOCK_I);
    RD_I = 1'b0;
    PHASE_S1_I = 1'b0;
    chk({11'h000, RVALID_O, RDATA_O}, {11'h000, 1'b1, e});
  endtask : rd

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {CLOCK_I, WR_I, RD_I, PHASE_S1_I, PHASE_S2_I, IND_SIDE_I} = '0;
    {ADDR_I, WDATA_I, ext_v, bad_count, check_count, cyc} = '0;
    INSTR_I = IOP_PLAIN;
    RST_I = 1'b1;
    repeat (12) @(negedge CLOCK_I);
    RST_I = 1'b0;
    for (int i = 3; i < 9; i++) rd(ra[i], IOP_PLAIN, 1'b0, 8'h00);
    chk({P1_OE_O, P3_OE_O, P4_OE_O, P6_OE_O}, 20'h0);
    // every register except the sixth port latch, widths of the four ports
    // latch-class reads only on read-write registers
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], 8'hFF);
      rd(ra[i], IOP_EXCHANGE, 1'b0, i == 6 ? 8'h0F : rw[i]);
    end
    chk({P1_OE_O, P3_OE_O, P4_OE_O, P6_OE_O}, 20'h4000F);
    // sixth port latch was never written and still holds zero
    chk({P1_OUT_O, P3_OUT_O, P4_OUT_O, P6_OUT_O}, 20'h7FFF0);
    wr(16'h0003, 8'h0F);
    chk(P3_OE_O, 8'hF0);
    wr(16'h1F83, 8'h00);
    chk(P3_OE_O, 8'hFF);
    // third port as input, latch differs from pins
    wr(16'h1F89, 8'h00);
    wr(16'h0003, 8'hA5);
    ext_v[17:10] = 8'h3C;
    repeat (3) @(negedge CLOCK_I);
    for (int i = 0; i < 7; i++) begin
      rd(16'h0003, iop_instr_t'(i), 1'b0, i == 0 ? 8'h3C : 8'hA5);
    end
    rd(16'h0003, IOP_ALU_IND, 1'b1, 8'h3C);
    ext_v[17:10] = 8'hC3;
    repeat (3) @(negedge CLOCK_I);
    rd(16'h0003, IOP_PLAIN, 1'b0, 8'hC3);
    // sixth port reads its pins even for latch classes
    wr(16'h1F8C, 8'h00);
    wr(16'h0006, 8'h05);
    ext_v[3:0] = 4'h9;
    repeat (3) @(negedge CLOCK_I);
    rd(16'h0006, IOP_EXCHANGE, 1'b0, 8'h09);
    wr(16'h1F8C, 8'h0F);
    repeat (3) @(negedge CLOCK_I);
    rd(16'h0006, IOP_BIT_MODIFY, 1'b0, 8'h05);
    chk(HIT_O, 1'b1);
    wr(16'h1FCC, 8'hFF);
    rd(16'h1FCC, IOP_PLAIN, 1'b0, 8'h00);
    rd(16'h1FFF, IOP_PLAIN, 1'b0, 8'h00);
    chk(HIT_O, 1'b0);
    // strobes without their bus state are ignored
    @(negedge CLOCK_I);
    ADDR_I = 16'h0003;
    WR_I = 1'b1;
    RD_I = 1'b1;
    @(negedge CLOCK_I);
    WR_I = 1'b0;
    RD_I = 1'b0;
    chk(RVALID_O, 1'b0);
    chk(P3_OUT_O, 8'hA5);
    RST_I = 1'b1;
    repeat (3) @(negedge CLOCK_I);
    RST_I = 1'b0;
    chk({P1_OUT_O, P3_OUT_O, P4_OUT_O, P6_OUT_O}, 20'h0);
    chk({P1_OE_O, P3_OE_O, P4_OE_O, P6_OE_O}, 20'h0);
    report_and_stop();
  end
endmodule : iop_ports_tb_top

`default_nettype wire

//--- verilog/iop_consts.svh
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH

// number of ports and the widest port
`define IOP_NUM_PORTS        4
`define IOP_MAX_WIDTH        8
`define IOP_TOTAL_PINS       19

// port widths: first, third, fourth and sixth port
`define IOP_W_PORT1          1
`define IOP_W_PORT3          8
`define IOP_W_PORT4          6
`define IOP_W_PORT6          4

// output latch addresses (special function register space)
`define IOP_PORT1_DATA_ADDR  16'h0001
`define IOP_PORT3_DATA_ADDR  16'h0003
`define IOP_PORT4_DATA_ADDR  16'h0004
`define IOP_PORT6_DATA_ADDR  16'h0006

// direction control addresses
`define IOP_PORT1_DIR_ADDR   16'h000B
`define IOP_PORT3_DIR_ADDR   16'h1F89
`define IOP_PORT4_DIR_ADDR   16'h1F8A
`define IOP_PORT6_DIR_ADDR   16'h1F8C

// open-drain select addresses (third and fourth port only)
`define IOP_PORT3_OD_ADDR    16'h1F83
`define IOP_PORT4_OD_ADDR    16'h1F84

// reserved block at the top of the data buffer space
`define IOP_RSVD_LO          16'h1FCC
`define IOP_RSVD_HI          16'h1FFF

// reset values of latch, direction and open-drain select
`define IOP_LATCH_RESET      8'h00
`define IOP_DIR_RESET        8'h00
`define IOP_OD_RESET         8'h00

// ports that always read the pin level (bit n = port index n)
`define IOP_PROG_PORT_MASK   4'h8

`endif

//--- verilog/iop_pkg.sv
`default_nettype none

`include "iop_consts.svh"

package iop_pkg;

  // source of a port read as the executing instruction sees it
  typedef enum logic [2:0] {
    IOP_PLAIN,
    IOP_EXCHANGE,
    IOP_BIT_MODIFY,
    IOP_CARRY_BIT,
    IOP_ALU_IMM,
    IOP_ALU_IND,
    IOP_MASKED_XOR
  } iop_instr_t;

  typedef logic [7:0]  iop_byte_t;
  typedef logic [15:0] iop_addr_t;

endpackage : iop_pkg

`default_nettype wire

//--- verilog/iop_port.sv
`default_nettype none

`include "iop_consts.svh"

// one port: output latch, direction, open-drain select, pin synchroniser
module iop_port #(
  parameter int W     = 8,
  parameter bit HAS_OD = 1'b1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_latch_i,
  input  wire logic         wr_dir_i,
  input  wire logic         wr_od_i,
  output logic      [W-1:0] latch_o,
  output logic      [W-1:0] dir_o,
  output logic      [W-1:0] od_o,
  output logic      [W-1:0] pin_lvl_o,
  output logic      [W-1:0] pin_out_o,
  output logic      [W-1:0] pin_oe_o
);
  import iop_pkg::*;

  typedef struct packed {
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] od;
    logic [W-1:0] meta;
    logic [W-1:0] lvl;
  } iop_port_state_t;

  iop_port_state_t st_q;
  iop_port_state_t st_d;

  // next-state: register writes and pin synchroniser
  always_comb begin
    st_d      = st_q;
    st_d.meta = pin_i;
    st_d.lvl  = st_q.meta;
    if (wr_latch_i) begin
      st_d.latch = wdata_i[W-1:0];
    end
    if (wr_dir_i) begin
      st_d.dir = wdata_i[W-1:0];
    end
    if (wr_od_i && HAS_OD) begin
      st_d.od = wdata_i[W-1:0];
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.latch <= W'(`IOP_LATCH_RESET);
      st_q.dir   <= W'(`IOP_DIR_RESET);
      st_q.od    <= W'(`IOP_OD_RESET);
      st_q.meta  <= '0;
      st_q.lvl   <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // pin drivers: open-drain releases the pin for a one
  always_comb begin
    latch_o   = st_q.latch;
    dir_o     = st_q.dir;
    od_o      = st_q.od;
    pin_lvl_o = st_q.lvl;
    pin_out_o = st_q.latch;
    pin_oe_o  = st_q.dir & (~st_q.od | ~st_q.latch);
  end

endmodule : iop_port

`default_nettype wire

//--- verilog/iop_ports.sv
`default_nettype none

`include "iop_consts.svh"

// Overview of operation
// - output latch keeps driving written value
// - pin read returns the two-flop synchronised level, no latch
// - pins sampled in read-cycle state S1
// - latch written in write-cycle state S2
// - listed modify instructions read the latch
// - indirect ALU: source latch, pointer operand pin
// - programmable ports always read the pins
// - four ports, 19 pins: 1, 8, 6, 4
// - reset clears direction and output latch
// - open-drain select per bit, resets tri-state
module iop_ports (
  input  wire logic               CLOCK_I,
  input  wire logic               RST_I,
  input  wire iop_pkg::iop_addr_t ADDR_I,
  input  wire iop_pkg::iop_byte_t WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  input  wire logic               PHASE_S1_I,
  input  wire logic               PHASE_S2_I,
  input  wire iop_pkg::iop_instr_t INSTR_I,
  input  wire logic               IND_SIDE_I,
  output logic                    HIT_O,
  output iop_pkg::iop_byte_t      RDATA_O,
  output logic                    RVALID_O,
  input  wire logic [0:0]         P1_PIN_I,
  output logic      [0:0]         P1_OUT_O,
  output logic      [0:0]         P1_OE_O,
  input  wire logic [7:0]         P3_PIN_I,
  output logic      [7:0]         P3_OUT_O,
  output logic      [7:0]         P3_OE_O,
  input  wire logic [5:0]         P4_PIN_I,
  output logic      [5:0]         P4_OUT_O,
  output logic      [5:0]         P4_OE_O,
  input  wire logic [3:0]         P6_PIN_I,
  output logic      [3:0]         P6_OUT_O,
  output logic      [3:0]         P6_OE_O
);
  import iop_pkg::*;

  localparam int NP = `IOP_NUM_PORTS;
  // ports that never take the latch as read source
  localparam logic [NP-1:0] prog_port_mask = `IOP_PROG_PORT_MASK;

  // width of each port by index
  function automatic int port_width(input int idx);
    case (idx)
      0:       port_width = `IOP_W_PORT1;
      1:       port_width = `IOP_W_PORT3;
      2:       port_width = `IOP_W_PORT4;
      default: port_width = `IOP_W_PORT6;
    endcase
  endfunction : port_width

  // output latch address of each port
  function automatic iop_addr_t data_addr(input int idx);
    case (idx)
      0:       data_addr = `IOP_PORT1_DATA_ADDR;
      1:       data_addr = `IOP_PORT3_DATA_ADDR;
      2:       data_addr = `IOP_PORT4_DATA_ADDR;
      default: data_addr = `IOP_PORT6_DATA_ADDR;
    endcase
  endfunction : data_addr

  // direction control address of each port
  function automatic iop_addr_t dir_addr(input int idx);
    case (idx)
      0:       dir_addr = `IOP_PORT1_DIR_ADDR;
      1:       dir_addr = `IOP_PORT3_DIR_ADDR;
      2:       dir_addr = `IOP_PORT4_DIR_ADDR;
      default: dir_addr = `IOP_PORT6_DIR_ADDR;
    endcase
  endfunction : dir_addr

  // open-drain select address; only third and fourth port have one
  function automatic iop_addr_t od_addr(input int idx);
    case (idx)
      1:       od_addr = `IOP_PORT3_OD_ADDR;
      default: od_addr = `IOP_PORT4_OD_ADDR;
    endcase
  endfunction : od_addr

  function automatic bit has_od(input int idx);
    has_od = (idx == 1) || (idx == 2);
  endfunction : has_od

  typedef struct packed {
    iop_byte_t rdata;
    logic      rvalid;
  } iop_top_state_t;

  iop_top_state_t st_q;
  iop_top_state_t st_d;

  // padded per-port views of pins and register contents
  iop_byte_t pin_pad   [NP];
  iop_byte_t out_pad   [NP];
  iop_byte_t oe_pad    [NP];
  iop_byte_t latch_pad [NP];
  iop_byte_t dir_pad   [NP];
  iop_byte_t od_pad    [NP];
  iop_byte_t lvl_pad   [NP];

  logic [NP-1:0] hit_data;
  logic [NP-1:0] hit_dir;
  logic [NP-1:0] hit_od;
  logic          wr_en;
  logic          rd_en;
  logic          want_latch;

  assign wr_en = WR_I & PHASE_S2_I;
  assign rd_en = RD_I & PHASE_S1_I;

  // map the four pin groups into the padded arrays
  assign pin_pad[0] = {7'h00, P1_PIN_I};
  assign pin_pad[1] = P3_PIN_I;
  assign pin_pad[2] = {2'h0, P4_PIN_I};
  assign pin_pad[3] = {4'h0, P6_PIN_I};

  // pin drivers back out to the port groups
  assign P1_OUT_O = out_pad[0][0:0];
  assign P1_OE_O  = oe_pad[0][0:0];
  assign P3_OUT_O = out_pad[1];
  assign P3_OE_O  = oe_pad[1];
  assign P4_OUT_O = out_pad[2][5:0];
  assign P4_OE_O  = oe_pad[2][5:0];
  assign P6_OUT_O = out_pad[3][3:0];
  assign P6_OE_O  = oe_pad[3][3:0];

  // four ports of 1, 8, 6 and 4 pins
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      localparam int W = port_width(g);
      localparam bit O = has_od(g);

      logic [W-1:0] latch_w;
      logic [W-1:0] dir_w;
      logic [W-1:0] od_w;
      logic [W-1:0] lvl_w;
      logic [W-1:0] out_w;
      logic [W-1:0] oe_w;

      // address decode for this port
      assign hit_data[g] = (ADDR_I == data_addr(g));
      assign hit_dir[g]  = (ADDR_I == dir_addr(g));
      assign hit_od[g]   = O && (ADDR_I == od_addr(g));

      iop_port #(
        .W      (W),
        .HAS_OD (O)
      ) u_port (
        .clk_i      (CLOCK_I),
        .rst_i      (RST_I),
        .pin_i      (pin_pad[g][W-1:0]),
        .wdata_i    (WDATA_I),
        .wr_latch_i (wr_en & hit_data[g]),
        .wr_dir_i   (wr_en & hit_dir[g]),
        .wr_od_i    (wr_en & hit_od[g]),
        .latch_o    (latch_w),
        .dir_o      (dir_w),
        .od_o       (od_w),
        .pin_lvl_o  (lvl_w),
        .pin_out_o  (out_w),
        .pin_oe_o   (oe_w)
      );

      // zero-extend each view to a byte; unused bits read as zero
      assign latch_pad[g] = 8'(latch_w);
      assign dir_pad[g]   = 8'(dir_w);
      assign od_pad[g]    = 8'(od_w);
      assign lvl_pad[g]   = 8'(lvl_w);
      assign out_pad[g]   = 8'(out_w);
      assign oe_pad[g]    = 8'(oe_w);
    end
  endgenerate

  // instruction class decides latch or pin as read source
  always_comb begin
    case (INSTR_I)
      IOP_EXCHANGE,
      IOP_BIT_MODIFY,
      IOP_CARRY_BIT,
      IOP_ALU_IMM,
      IOP_MASKED_XOR: want_latch = 1'b1;
      // source side latch, pointer side pin
      IOP_ALU_IND:    want_latch = ~IND_SIDE_I;
      default:        want_latch = 1'b0;
    endcase
  end

  // address hit: reserved block and unmapped addresses give no hit
  assign HIT_O = |{hit_data, hit_dir, hit_od};

  // read mux and read data register
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    if (rd_en) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = 8'h00;
      for (int i = 0; i < NP; i++) begin
        if (hit_data[i]) begin
          if (want_latch && !prog_port_mask[i]) begin
            st_d.rdata = latch_pad[i];
          end else begin
            st_d.rdata = lvl_pad[i];
          end
        end else if (hit_dir[i]) begin
          st_d.rdata = dir_pad[i];
        end else if (hit_od[i]) begin
          st_d.rdata = od_pad[i];
        end
      end
    end
  end

  // read data register
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      st_q.rdata  <= 8'h00;
      st_q.rvalid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign RDATA_O  = st_q.rdata;
  assign RVALID_O = st_q.rvalid;

endmodule : iop_ports

`default_nettype wire
